// ### ptcs_consts.svh
`ifndef PTCS_CONSTS_SVH
`define PTCS_CONSTS_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PTCS_OFS_TX_MULTI_COLL   12'h000
`define PTCS_OFS_TX_EXCESS_COLL  12'h004
`define PTCS_OFS_TX_LATE_COLL    12'h008
`define PTCS_OFS_TX_UNDERRUN     12'h00c
`define PTCS_OFS_TX_CARRIER_LOSS 12'h010
`define PTCS_OFS_TX_GOOD_BYTES   12'h014
`define PTCS_OFS_BIN_64          12'h018
`define PTCS_OFS_BIN_65_127      12'h01c
`define PTCS_OFS_BIN_128_255     12'h020
// ----------------------------------------------------------------------------
// Reset values and thresholds
// ----------------------------------------------------------------------------
`define PTCS_CNT_RESET           32'h0000_0000
`define PTCS_MULTI_MIN_COLL      5'h02
`define PTCS_MULTI_MAX_COLL      5'h0f
`define PTCS_EXCESS_COLL         5'h10
`define PTCS_LATE_BIT_TIMES      16'h0200
`define PTCS_LEN_64              16'h0040
`define PTCS_LEN_65              16'h0041
`define PTCS_LEN_127             16'h007f
`define PTCS_LEN_128             16'h0080
`define PTCS_LEN_255             16'h00ff
`endif

// ### ptcs_pkg.sv
`default_nettype none
package ptcs_pkg;
  // Counter index in the state array
  typedef enum {
    CNT_MULTI, CNT_EXCESS, CNT_LATE, CNT_UNDER, CNT_CARRIER,
    CNT_BYTES, CNT_B64, CNT_B65, CNT_B128, CNT_NUM
  } ptcs_cnt_idx_t;
  // APB slave phase
  typedef enum {APB_IDLE, APB_DONE} ptcs_apb_st_t;
  // Whole module state
  typedef struct packed {
    logic [8:0][31:0] cnt;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    ptcs_apb_st_t     apb_st;
  } ptcs_state_t;
endpackage
`default_nettype wire

// ### ptcs_stats.sv
// Functional notes
// - Count success after 2-15 non-late collisions, no carrier loss/underrun.
// - Sixteen non-late collisions abandon frame; count unless carrier loss/underrun.
// - Collision beyond 512 bit-times is late; frame abandoned, late counter steps.
// - Late frame counted even after up to 15 earlier collisions.
// - Late collision excludes frame from multi and excessive counters.
// - Late frames counted despite CRC errors, carrier loss or underrun.
// - Underrun counter only steps on reported underrun; normally stays zero.
// - Carrier dropped or absent during transmit steps carrier-loss counter.
// - Carrier state ignored for received frames.
// - Carrier-loss frames run to completion; MAC reports once at end.
// - Carrier-loss frames counted despite CRC errors or underrun.
// - Good transmit frame lengths are summed into byte counter.
// - Exactly 64-byte qualifying frames, either direction, step 64 bin.
// - Transmit cut by carrier loss to 64 bytes still lands in 64 bin.
// - CRC, code, alignment, overrun errors do not affect 64 bin.
// - 65..127 byte qualifying frames step that bin.
// - 128..255 byte qualifying frames step that bin.
// - Bins ignore CRC/code/align/underrun/overrun; late, excessive, carrier exclude.
// - Receive and transmit share the same histogram counters.
// - Only data or MAC control frames to any address are considered.
`timescale 1ns/1ns
`default_nettype none
`include "ptcs_consts.svh"
module ptcs_stats #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output var  logic [31:0]       prdata_o,
  output var  logic              pready_o,
  output var  logic              pslverr_o,
  // Transmit frame status, one-cycle pulse at frame end
  input  wire logic              tx_done_i,
  input  wire logic              tx_eligible_i,
  input  wire logic [4:0]        tx_coll_cnt_i,
  input  wire logic              tx_late_coll_i,
  input  wire logic              tx_carrier_loss_i,
  input  wire logic              tx_underrun_i,
  input  wire logic [15:0]       tx_len_i,
  // Receive frame status, one-cycle pulse at frame end
  input  wire logic              rx_done_i,
  input  wire logic              rx_eligible_i,
  input  wire logic [15:0]       rx_len_i,
  // Good transmit byte counter copy for the MAC
  output var  logic [31:0]       tx_good_byte_count_o
);
  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  if (ADDR_W < 6) begin : g_chk
    $error("ptcs_stats: ADDR_W too small for the register map");
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Size bin select for one frame length
  function automatic logic [2:0] bin_of(input logic [15:0] len);
    logic [2:0] b;
    b = 3'h0;
    if (len == `PTCS_LEN_64) begin
      b = 3'h1;
    end else if (len >= `PTCS_LEN_65 && len <= `PTCS_LEN_127) begin
      b = 3'h2;
    end else if (len >= `PTCS_LEN_128 && len <= `PTCS_LEN_255) begin
      b = 3'h4;
    end
    return b;
  endfunction

  // Increment count of one bin, 0..2
  function automatic logic [31:0] add2(input logic [31:0] c, input logic a, input logic b);
    return c + {30'h0, a & b, a ^ b};
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  ptcs_pkg::ptcs_state_t st_ff;
  ptcs_pkg::ptcs_state_t nxt_st;

  logic        tx_ev;
  logic        rx_ev;
  logic        tx_late;
  logic        tx_excess;
  logic        tx_multi;
  logic        tx_good;
  logic        tx_bin_ok;
  logic        tx_cl64;
  logic [2:0]  tx_bin;
  logic [2:0]  rx_bin;
  logic [31:0] rd_val;
  logic        rd_hit;

  // --------------------------------------------------------------------------
  // Frame classification
  // --------------------------------------------------------------------------
  // Only eligible data or control frames are considered
  assign tx_ev     = tx_done_i & tx_eligible_i;
  assign rx_ev     = rx_done_i & rx_eligible_i;
  // Late collision dominates regardless of other errors
  assign tx_late   = tx_ev & tx_late_coll_i;
  assign tx_excess = tx_ev & ~tx_late_coll_i & (tx_coll_cnt_i >= `PTCS_EXCESS_COLL)
                     & ~tx_carrier_loss_i & ~tx_underrun_i;
  assign tx_multi  = tx_ev & ~tx_late_coll_i & ~tx_carrier_loss_i & ~tx_underrun_i
                     & (tx_coll_cnt_i >= `PTCS_MULTI_MIN_COLL)
                     & (tx_coll_cnt_i <= `PTCS_MULTI_MAX_COLL);
  assign tx_good   = tx_ev & ~tx_late_coll_i & (tx_coll_cnt_i < `PTCS_EXCESS_COLL)
                     & ~tx_carrier_loss_i & ~tx_underrun_i;
  // Bins exclude late, excessive and carrier loss; underrun ignored
  assign tx_bin_ok = tx_ev & ~tx_late_coll_i & (tx_coll_cnt_i < `PTCS_EXCESS_COLL)
                     & ~tx_carrier_loss_i;
  // A send cut by carrier loss to exactly 64 bytes still lands in the 64 bin
  assign tx_cl64   = tx_ev & ~tx_late_coll_i & (tx_coll_cnt_i < `PTCS_EXCESS_COLL)
                     & tx_carrier_loss_i & (tx_len_i == `PTCS_LEN_64);
  assign tx_bin    = tx_bin_ok ? bin_of(tx_len_i) : (tx_cl64 ? 3'h1 : 3'h0);
  assign rx_bin    = rx_ev ? bin_of(rx_len_i) : 3'h0;

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr_i == ADDR_W'(`PTCS_OFS_TX_MULTI_COLL)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_MULTI];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_TX_EXCESS_COLL)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_EXCESS];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_TX_LATE_COLL)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_LATE];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_TX_UNDERRUN)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_UNDER];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_TX_CARRIER_LOSS)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_CARRIER];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_TX_GOOD_BYTES)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_BYTES];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_BIN_64)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_B64];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_BIN_65_127)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_B65];
    end else if (paddr_i == ADDR_W'(`PTCS_OFS_BIN_128_255)) begin
      rd_val = st_ff.cnt[ptcs_pkg::CNT_B128];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Collision and error counters
    nxt_st.cnt[ptcs_pkg::CNT_MULTI]   = add2(st_ff.cnt[ptcs_pkg::CNT_MULTI], tx_multi, 1'b0);
    nxt_st.cnt[ptcs_pkg::CNT_EXCESS]  = add2(st_ff.cnt[ptcs_pkg::CNT_EXCESS], tx_excess, 1'b0);
    nxt_st.cnt[ptcs_pkg::CNT_LATE]    = add2(st_ff.cnt[ptcs_pkg::CNT_LATE], tx_late, 1'b0);
    nxt_st.cnt[ptcs_pkg::CNT_UNDER]   = add2(st_ff.cnt[ptcs_pkg::CNT_UNDER],
                                             tx_ev & tx_underrun_i, 1'b0);
    nxt_st.cnt[ptcs_pkg::CNT_CARRIER] = add2(st_ff.cnt[ptcs_pkg::CNT_CARRIER],
                                             tx_ev & tx_carrier_loss_i, 1'b0);
    // Byte sum of good frames, wraps
    if (tx_good) begin
      nxt_st.cnt[ptcs_pkg::CNT_BYTES] = st_ff.cnt[ptcs_pkg::CNT_BYTES]
                                        + {16'h0000, tx_len_i};
    end
    // Shared histogram bins, both paths may land in one cycle
    nxt_st.cnt[ptcs_pkg::CNT_B64]  = add2(st_ff.cnt[ptcs_pkg::CNT_B64], tx_bin[0], rx_bin[0]);
    nxt_st.cnt[ptcs_pkg::CNT_B65]  = add2(st_ff.cnt[ptcs_pkg::CNT_B65], tx_bin[1], rx_bin[1]);
    nxt_st.cnt[ptcs_pkg::CNT_B128] = add2(st_ff.cnt[ptcs_pkg::CNT_B128], tx_bin[2], rx_bin[2]);
    // APB: answer in access phase, one wait state
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    case (st_ff.apb_st)
      ptcs_pkg::APB_IDLE: begin
        if (psel_i && penable_i) begin
          nxt_st.pready  = 1'b1;
          nxt_st.apb_st  = ptcs_pkg::APB_DONE;
          nxt_st.prdata  = pwrite_i ? 32'h0000_0000 : rd_val;
          nxt_st.pslverr = pwrite_i | ~rd_hit;
        end
      end
      ptcs_pkg::APB_DONE: begin
        nxt_st.apb_st = ptcs_pkg::APB_IDLE;
      end
      default: begin
        nxt_st.apb_st = ptcs_pkg::APB_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o             = st_ff.prdata;
  assign pready_o             = st_ff.pready;
  assign pslverr_o            = st_ff.pslverr;
  assign tx_good_byte_count_o = st_ff.cnt[ptcs_pkg::CNT_BYTES];

  // Write data is not used by read-only counters
  logic unused_ok;
  assign unused_ok = ^pwdata_i;
endmodule
`default_nettype wire

// ### ptcs_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module ptcs_mac_model (
  // Clock
  input  wire logic        clk_i,
  // Frame status towards the counters
  output var  logic        tx_done_o,
  output var  logic        tx_eligible_o,
  output var  logic [4:0]  tx_coll_cnt_o,
  output var  logic        tx_late_coll_o,
  output var  logic        tx_carrier_loss_o,
  output var  logic        tx_underrun_o,
  output var  logic [15:0] tx_len_o,
  output var  logic        rx_done_o,
  output var  logic        rx_eligible_o,
  output var  logic [15:0] rx_len_o
);
  // Idle state at time zero
  initial begin
    {tx_done_o, tx_eligible_o, tx_coll_cnt_o, tx_late_coll_o} = '0;
    {tx_carrier_loss_o, tx_underrun_o, tx_len_o} = '0;
    {rx_done_o, rx_eligible_o, rx_len_o} = '0;
  end
  // One status pulse at frame end; qualifiers are scrambled outside it
  task automatic frame(input logic tx, rx, el, input logic [4:0] c,
                       input logic lt, cl, ur, input logic [15:0] n);
    @(posedge clk_i);
    tx_done_o <= tx;
    rx_done_o <= rx;
    {tx_eligible_o, rx_eligible_o} <= {el, el};
    {tx_coll_cnt_o, tx_late_coll_o, tx_carrier_loss_o, tx_underrun_o} <= {c, lt, cl, ur};
    {tx_len_o, rx_len_o} <= {n, n};
    @(posedge clk_i);
    {tx_done_o, rx_done_o} <= 2'h0;
    {tx_eligible_o, rx_eligible_o} <= {~el, ~el};
    {tx_coll_cnt_o, tx_late_coll_o, tx_carrier_loss_o, tx_underrun_o} <= ~{c, lt, cl, ur};
    {tx_len_o, rx_len_o} <= ~{n, n};
  endtask
endmodule
`default_nettype wire

// ### ptcs_stats_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module ptcs_stats_monitor #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and APB
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       prdata_o,
  input  wire logic              pready_o,
  input  wire logic              pslverr_o,
  // Transmit status and byte counter copy
  input  wire logic              tx_done_i,
  input  wire logic              tx_eligible_i,
  input  wire logic [4:0]        tx_coll_cnt_i,
  input  wire logic              tx_late_coll_i,
  input  wire logic              tx_carrier_loss_i,
  input  wire logic              tx_underrun_i,
  input  wire logic [15:0]       tx_len_i,
  input  wire logic [31:0]       tx_good_byte_count_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Good transmitted frame seen this cycle
  logic good;
  assign good = tx_done_i && tx_eligible_i && !tx_late_coll_i && (tx_coll_cnt_i < 5'h10)
                && !tx_carrier_loss_i && !tx_underrun_i;
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  AST_ONE_WAIT: assert property (s_acc |=> pready_o)
    else $error("access not answered after one wait state");
  AST_PULSE: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  AST_WR_REFUSED: assert property (pready_o && pwrite_i |-> pslverr_o)
    else $error("write to read-only counter not refused");
  AST_UNMAPPED: assert property (pready_o && paddr_i > 'h020 |-> pslverr_o && prdata_o == 0)
    else $error("unmapped read not refused with zero data");
  AST_RD_HOLD: assert property (!pready_o |-> $stable(prdata_o))
    else $error("read data changed outside an answer");
  AST_BYTES_ADD: assert property (good |=>
    tx_good_byte_count_o == $past(tx_good_byte_count_o) + $past(tx_len_i))
    else $error("good frame length not added");
  AST_BYTES_KEEP: assert property (!good |=> $stable(tx_good_byte_count_o))
    else $error("byte counter moved without a good frame");
  AST_RST_ZERO: assert property ($rose(rst_n_i) |-> tx_good_byte_count_o == 0 && !pready_o)
    else $error("outputs not cleared by reset");
endmodule
bind ptcs_stats ptcs_stats_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .tx_done_i,
  .tx_eligible_i, .tx_coll_cnt_i, .tx_late_coll_i, .tx_carrier_loss_i, .tx_underrun_i,
  .tx_len_i, .tx_good_byte_count_o);
`default_nettype wire

// ### tb_ptcs_stats.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ptcs_stats;
  logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic        tx_done_i, tx_eligible_i, tx_late_coll_i, tx_carrier_loss_i, tx_underrun_i;
  logic        rx_done_i, rx_eligible_i;
  logic [4:0]  tx_coll_cnt_i;
  logic [11:0] paddr_i;
  logic [15:0] tx_len_i, rx_len_i;
  logic [31:0] pwdata_i, prdata_o, tx_good_byte_count_o, d;
  logic [31:0] exp [10];
  logic [15:0] lens [6] = '{16'h003f, 16'h0041, 16'h007f, 16'h00ff, 16'h0100, 16'h0081};
  int          miscompares, n_compared;
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  ptcs_stats dut (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .tx_done_i, .tx_eligible_i, .tx_coll_cnt_i,
    .tx_late_coll_i, .tx_carrier_loss_i, .tx_underrun_i, .tx_len_i, .rx_done_i,
    .rx_eligible_i, .rx_len_i, .tx_good_byte_count_o);
  ptcs_mac_model mac (.clk_i(sys_clk_i), .tx_done_o(tx_done_i), .tx_eligible_o(tx_eligible_i),
    .tx_coll_cnt_o(tx_coll_cnt_i), .tx_late_coll_o(tx_late_coll_i),
    .tx_carrier_loss_o(tx_carrier_loss_i), .tx_underrun_o(tx_underrun_i), .tx_len_o(tx_len_i),
    .rx_done_o(rx_done_i), .rx_eligible_o(rx_eligible_i), .rx_len_o(rx_len_i));
  // Verdict and end of run
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  // APB transfer, waits for ready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     output logic [31:0] rd, output logic er);
    bit ok;
    ok = 1'b0;
    @(posedge sys_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, wr, a, 32'hffff_ffff};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Ready is looked at mid-cycle, where it stands settled
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge sys_clk_i);
      ok = (pready_o === 1'b1);
    end
    rd = prdata_o;
    er = pslverr_o;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH %0t no ready from slave", $time);
    end
    // Request held through the edge that samples ready high
    @(posedge sys_clk_i);
    {psel_i, penable_i} <= 2'h0;
  endtask
  // Read every counter and compare with the expected table
  task automatic check_all;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 12'(i * 4), d, e);
      cmp(d, exp[i]);
      cmp({31'h0, e}, 32'h0);
    end
    cmp(tx_good_byte_count_o, exp[5]);
  endtask
  // Send one frame status and update the expected counters
  task automatic frame(input logic tx, rx, el, input logic [4:0] c,
                       input logic lt, cl, ur, input logic [15:0] n);
    int  b;
    logic g;
    b = (n == 16'h0040) ? 6 : (n >= 16'h0041 && n <= 16'h007f) ? 7 :
        (n >= 16'h0080 && n <= 16'h00ff) ? 8 : 9;
    g = !lt && c < 5'h10 && !cl;
    mac.frame(tx, rx, el, c, lt, cl, ur, n);
    if (tx && el) begin
      if (g && !ur && c >= 5'h02) exp[0]++;
      if (!lt && c >= 5'h10 && !cl && !ur) exp[1]++;
      if (lt) exp[2]++;
      if (ur) exp[3]++;
      if (cl) exp[4]++;
      if (g && !ur) exp[5] += {16'h0, n};
      if (g) exp[b]++;
      if (!lt && c < 5'h10 && cl && n == 16'h0040) exp[6]++;
    end
    if (rx && el) exp[b]++;
    check_all;
  endtask
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    test_done;
  end
  // Main sequence
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    foreach (exp[i]) exp[i] = 32'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    check_all;
    apb(1'b1, 12'h000, d, e);
    cmp({31'h0, e}, 32'h1);
    apb(1'b0, 12'h024, d, e);
    cmp({31'h0, e}, 32'h1);
    cmp(d, 32'h0);
    frame(1, 0, 1, 5'h02, 0, 0, 0, 16'h0040);
    frame(1, 0, 1, 5'h0f, 0, 0, 0, 16'h0064);
    frame(1, 0, 1, 5'h01, 0, 0, 0, 16'h00c8);
    frame(1, 0, 1, 5'h10, 0, 0, 0, 16'h0040);
    frame(1, 0, 1, 5'h10, 0, 0, 1, 16'h0040);
    frame(1, 0, 1, 5'h0f, 1, 1, 1, 16'h007f);
    frame(1, 0, 1, 5'h00, 1, 0, 0, 16'h0040);
    frame(1, 0, 1, 5'h00, 0, 1, 1, 16'h012c);
    frame(1, 0, 1, 5'h01, 0, 1, 0, 16'h0040);
    frame(1, 0, 1, 5'h03, 0, 0, 1, 16'h0080);
    frame(1, 1, 1, 5'h00, 0, 0, 0, 16'h0040);
    frame(0, 1, 1, 5'h00, 0, 1, 0, 16'h0080);
    frame(1, 1, 0, 5'h02, 0, 0, 0, 16'h0040);
    foreach (lens[i]) frame(0, 1, 1, 5'h00, 0, 0, 0, lens[i]);
    test_done;
  end
endmodule
`default_nettype wire
